// ==== hdl/scps_defs.svh ====
`ifndef SCPS_DEFS_SVH
`define SCPS_DEFS_SVH

// register byte offsets
`define SCPS_OFF_CTRL     8'h00
`define SCPS_OFF_DIV      8'h04
`define SCPS_OFF_FBD      8'h08
`define SCPS_OFF_STAT     8'h0c

// control register fields
`define SCPS_SWREQ_BIT    0
`define SCPS_LOCK_BIT     5
`define SCPS_NEW_LSB      8
`define SCPS_CUR_LSB      12

// divisor register fields
`define SCPS_PRE_LSB      0
`define SCPS_POST_LSB     6
`define SCPS_RCDIV_LSB    8

// feedback and status register fields
`define SCPS_FBD_LSB      0
`define SCPS_MODE_LSB     0
`define SCPS_PMODE_LSB    4

// reset values
`define SCPS_DIV_RST      10'h020
`define SCPS_FBD_RST      9'h030

// counts and offsets of the divider chain, boot sequence and bus
`define SCPS_LOCK_CYC     12'd2048
`define SCPS_PRE_OFS      6'd1
`define SCPS_FB_OFS       12'd2
`define SCPS_RCDIV_BASE   9'd2
`define SCPS_RC16_LAST    4'hf
`define SCPS_BOOT_CAPT    2'd2
`define SCPS_BOOT_DONE    2'd3
`define SCPS_WORD_SIZE    3'b010

`endif

// ==== hdl/scps_pkg.sv ====
package scps_pkg;

  // oscillator selections, current and new
  typedef enum logic [2:0] {
    SRC_FAST_RC       = 3'h0,
    SRC_FAST_RC_PLL   = 3'h1,
    SRC_PRIMARY       = 3'h2,
    SRC_PRIMARY_PLL   = 3'h3,
    SRC_SECONDARY     = 3'h4,
    SRC_LOW_POWER_RC  = 3'h5,
    SRC_FAST_RC_DIV16 = 3'h6,
    SRC_FAST_RC_DIVN  = 3'h7
  } scps_src_t;

  // primary oscillator modes
  typedef enum logic [1:0] {
    PM_EXTERNAL = 2'h0,
    PM_CRYSTAL  = 2'h1,
    PM_FAST_XTL = 2'h2,
    PM_OFF      = 2'h3
  } scps_pmode_t;

  // the twelve clock modes
  typedef enum logic [3:0] {
    MODE_FAST_RC          = 4'h0,
    MODE_FAST_RC_PLL      = 4'h1,
    MODE_PRI_EXTERNAL     = 4'h2,
    MODE_PRI_CRYSTAL      = 4'h3,
    MODE_PRI_FAST_XTL     = 4'h4,
    MODE_PRI_EXTERNAL_PLL = 4'h5,
    MODE_PRI_CRYSTAL_PLL  = 4'h6,
    MODE_PRI_FAST_XTL_PLL = 4'h7,
    MODE_SECONDARY        = 4'h8,
    MODE_LOW_POWER_RC     = 4'h9,
    MODE_FAST_RC_DIV16    = 4'ha,
    MODE_FAST_RC_DIVN     = 4'hb
  } scps_mode_t;

  // switch sequencer, gray along idle-wait-swap
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_SWAP = 2'b11
  } scps_sw_t;

  // divisor register contents
  typedef struct packed {
    logic [2:0] rc_div;
    logic [1:0] post;
    logic [4:0] pre;
  } scps_div_t;

endpackage

// ==== hdl/scps_edge_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module scps_edge_sync (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // oscillator levels from pins
  input  wire logic [3:0] osc_in,
  // one-cycle pulse per rising edge
  output logic [3:0]      tick
);

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] last_q;
  logic [3:0] tick_q;
  logic [3:0] tick_d;

  // edge seen between second and third stage only
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
      assign tick_d[gi] = sync_q[gi] & ~last_q[gi];
    end
  endgenerate

  // two-stage synchroniser, history stage, pulse register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      last_q <= 4'h0;
      tick_q <= 4'h0;
    end else begin
      meta_q <= osc_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule // scps_edge_sync
`default_nettype wire

// ==== hdl/scps_clock_select.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "scps_defs.svh"
module scps_clock_select (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // oscillator pins
  input  wire logic        fast_rc_osc,
  input  wire logic        low_power_rc_osc,
  input  wire logic        secondary_osc,
  input  wire logic        primary_osc1,
  // nonvolatile configuration word
  input  wire logic [2:0]  initial_source_select,
  input  wire logic [1:0]  primary_mode_select,
  input  wire logic        config_blank,
  // clock products and status
  output logic             osc_tick,
  output logic             cycle_tick,
  output logic             watchdog_ref_tick,
  output logic             crystal_drive_en,
  output logic [2:0]       current_source,
  output logic [3:0]       clock_mode,
  output logic             pll_locked
);

  // selected tick out of the eight source taps
  function automatic logic pick_tick(input scps_pkg::scps_src_t s,
                                     input logic [7:0] v);
    pick_tick = v[s];
  endfunction

  // source runs through the pll
  function automatic logic is_pll(input scps_pkg::scps_src_t s);
    is_pll = (s == scps_pkg::SRC_FAST_RC_PLL) ||
             (s == scps_pkg::SRC_PRIMARY_PLL);
  endfunction

  // postscale factor, zero gives two
  function automatic logic [11:0] post_factor(input logic [1:0] f);
    case (f)
      2'h0:    post_factor = 12'd2;
      2'h1:    post_factor = 12'd4;
      default: post_factor = 12'd8;
    endcase
  endfunction

  // clock mode from source and primary mode
  function automatic scps_pkg::scps_mode_t mode_of(
    input scps_pkg::scps_src_t s, input scps_pkg::scps_pmode_t p);
    logic pll;
    pll = (s == scps_pkg::SRC_PRIMARY_PLL);
    case (s)
      scps_pkg::SRC_FAST_RC:       mode_of = scps_pkg::MODE_FAST_RC;
      scps_pkg::SRC_FAST_RC_PLL:   mode_of = scps_pkg::MODE_FAST_RC_PLL;
      scps_pkg::SRC_SECONDARY:     mode_of = scps_pkg::MODE_SECONDARY;
      scps_pkg::SRC_LOW_POWER_RC:  mode_of = scps_pkg::MODE_LOW_POWER_RC;
      scps_pkg::SRC_FAST_RC_DIV16: mode_of = scps_pkg::MODE_FAST_RC_DIV16;
      scps_pkg::SRC_FAST_RC_DIVN:  mode_of = scps_pkg::MODE_FAST_RC_DIVN;
      default: begin
        case (p)
          scps_pkg::PM_CRYSTAL:
            mode_of = pll ? scps_pkg::MODE_PRI_CRYSTAL_PLL
                          : scps_pkg::MODE_PRI_CRYSTAL;
          scps_pkg::PM_FAST_XTL:
            mode_of = pll ? scps_pkg::MODE_PRI_FAST_XTL_PLL
                          : scps_pkg::MODE_PRI_FAST_XTL;
          default:
            mode_of = pll ? scps_pkg::MODE_PRI_EXTERNAL_PLL
                          : scps_pkg::MODE_PRI_EXTERNAL;
        endcase
      end
    endcase
  endfunction

  // source edge pulses
  logic [3:0]              pin_tick;
  logic                    frc_tick;
  logic                    internal_low_power_rc_tick;
  logic                    sec_tick;
  logic                    pri_tick;
  logic [7:0]              tap;

  // bus state
  logic                    take;
  logic                    wr_q, wr_d;
  logic [7:0]              waddr_q, waddr_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    rdy_q;
  logic                    resp_q;
  logic                    wr_ctrl, wr_div, wr_fbd;

  // configuration capture
  logic [5:0]              cfg_meta_q;
  logic [5:0]              cfg_sync_q;
  logic [1:0]              boot_q, boot_d;
  logic                    boot_done;
  scps_pkg::scps_src_t     boot_src;

  // control state
  scps_pkg::scps_sw_t      sw_q, sw_d;
  scps_pkg::scps_src_t     cur_q, cur_d;
  scps_pkg::scps_src_t     new_q, new_d;
  scps_pkg::scps_pmode_t   pmode_q, pmode_d;
  scps_pkg::scps_div_t     div_q, div_d;
  logic [8:0]              fbd_q, fbd_d;
  logic                    swreq_q, swreq_d;
  logic                    sw_done;

  // pll state
  logic                    pll_use, pll_pri, pll_in, vco_tick, emit;
  logic                    pll_pri_q;
  logic [5:0]              pre_cnt_q, pre_cnt_d;
  logic [4:0]              act_pre_q, act_pre_d;
  logic [1:0]              act_post_q, act_post_d;
  logic [8:0]              act_fb_q, act_fb_d;
  logic [11:0]             acc_q, acc_d, n2, m;
  logic                    pll_tick_q, pll_tick_d;
  logic [11:0]             lock_cnt_q, lock_cnt_d;
  logic                    lock_q, lock_d;

  // fast rc dividers
  logic [3:0]              rc16_q, rc16_d;
  logic [7:0]              rcn_q, rcn_d, rcn_last;
  logic [2:0]              act_rc_q, act_rc_d;
  logic                    rc16_tick, rcn_tick;

  // output registers
  logic                    osc_q, osc_d, phase_q, phase_d, cyc_q, cyc_d;
  logic                    wdt_q, xdrv_q, xdrv_d;
  scps_pkg::scps_mode_t    mode_q, mode_d;

  // pin one carries external clock or crystal amplifier output
  scps_edge_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .osc_in  ({primary_osc1, secondary_osc, low_power_rc_osc, fast_rc_osc}),
    .tick    (pin_tick)
  );
  assign frc_tick  = pin_tick[0];
  assign internal_low_power_rc_tick = pin_tick[1];
  assign sec_tick  = pin_tick[2];
  assign pri_tick  = pin_tick[3];
  // taps indexed by source code
  assign tap = {rcn_tick, rc16_tick, internal_low_power_rc_tick, sec_tick,
                pll_tick_q, pri_tick, pll_tick_q, frc_tick};

  // bus address phase and read data, zero wait states
  always_comb begin
    take    = hsel & htrans[1] & hready;
    wr_d    = take & hwrite & (hsize == `SCPS_WORD_SIZE) &
              (haddr[31:8] == 24'h0);
    waddr_d = take ? haddr[7:0] : waddr_q;
    rdata_d = rdata_q;
    if (take & ~hwrite) begin
      rdata_d = 32'h0;
      case (haddr[7:0])
        `SCPS_OFF_CTRL: begin
          rdata_d[`SCPS_CUR_LSB +: 3]  = cur_q;
          rdata_d[`SCPS_NEW_LSB +: 3]  = new_q;
          rdata_d[`SCPS_LOCK_BIT]      = lock_q;
          rdata_d[`SCPS_SWREQ_BIT]     = swreq_q;
        end
        `SCPS_OFF_DIV: begin
          rdata_d[`SCPS_RCDIV_LSB +: 3] = div_q.rc_div;
          rdata_d[`SCPS_POST_LSB +: 2]  = div_q.post;
          rdata_d[`SCPS_PRE_LSB +: 5]   = div_q.pre;
        end
        `SCPS_OFF_FBD:  rdata_d[`SCPS_FBD_LSB +: 9] = fbd_q;
        `SCPS_OFF_STAT: begin
          rdata_d[`SCPS_MODE_LSB +: 4]  = mode_q;
          rdata_d[`SCPS_PMODE_LSB +: 2] = pmode_q;
        end
        default:        rdata_d = 32'h0;
      endcase
      if (haddr[31:8] != 24'h0) begin
        rdata_d = 32'h0;
      end
    end
  end
  assign wr_ctrl = wr_q & (waddr_q == `SCPS_OFF_CTRL);
  assign wr_div  = wr_q & (waddr_q == `SCPS_OFF_DIV);
  assign wr_fbd  = wr_q & (waddr_q == `SCPS_OFF_FBD);

  // bus registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0;
      rdy_q   <= 1'b1;
      resp_q  <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
      rdy_q   <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  // configuration word sampled two cycles after reset release
  assign boot_done = (boot_q == `SCPS_BOOT_DONE);
  assign boot_d    = boot_done ? boot_q : boot_q + 2'd1;
  assign boot_src  = cfg_sync_q[5] ? scps_pkg::SRC_FAST_RC
                   : scps_pkg::scps_src_t'(cfg_sync_q[2:0]);

  // source selection, switch sequencer and software fields
  always_comb begin
    sw_d    = sw_q;
    cur_d   = cur_q;
    new_d   = new_q;
    pmode_d = pmode_q;
    div_d   = div_q;
    fbd_d   = fbd_q;
    swreq_d = swreq_q;
    sw_done = 1'b0;
    if (boot_q == `SCPS_BOOT_CAPT) begin
      cur_d   = boot_src;
      new_d   = boot_src;
      pmode_d = scps_pkg::scps_pmode_t'(cfg_sync_q[4:3]);
    end
    case (sw_q)
      scps_pkg::SW_IDLE: begin
        if (swreq_q & boot_done) begin
          if (new_q == cur_q) begin
            sw_done = 1'b1;
          end else begin
            sw_d = scps_pkg::SW_WAIT;
          end
        end
      end
      scps_pkg::SW_WAIT: begin
        if (pick_tick(new_q, tap) & (~is_pll(new_q) | lock_q)) begin
          sw_d = scps_pkg::SW_SWAP;
        end
      end
      scps_pkg::SW_SWAP: begin
        if (pick_tick(cur_q, tap)) begin
          cur_d   = new_q;
          sw_done = 1'b1;
          sw_d    = scps_pkg::SW_IDLE;
        end
      end
      default: sw_d = scps_pkg::SW_IDLE;
    endcase
    if (sw_done) begin
      swreq_d = 1'b0;
    end
    if (wr_ctrl) begin
      if (!swreq_q) begin
        new_d = scps_pkg::scps_src_t'(hwdata[`SCPS_NEW_LSB +: 3]);
      end
      if (hwdata[`SCPS_SWREQ_BIT]) begin
        swreq_d = 1'b1;
      end
    end
    if (wr_div) begin
      div_d.rc_div = hwdata[`SCPS_RCDIV_LSB +: 3];
      div_d.post   = hwdata[`SCPS_POST_LSB +: 2];
      div_d.pre    = hwdata[`SCPS_PRE_LSB +: 5];
    end
    if (wr_fbd) begin
      fbd_d = hwdata[`SCPS_FBD_LSB +: 9];
    end
  end

  // control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_meta_q <= 6'h00;
      cfg_sync_q <= 6'h00;
      boot_q     <= 2'd0;
      sw_q       <= scps_pkg::SW_IDLE;
      cur_q      <= scps_pkg::SRC_FAST_RC;
      new_q      <= scps_pkg::SRC_FAST_RC;
      pmode_q    <= scps_pkg::PM_EXTERNAL;
      div_q      <= `SCPS_DIV_RST;
      fbd_q      <= `SCPS_FBD_RST;
      swreq_q    <= 1'b0;
    end else begin
      cfg_meta_q <= {config_blank, primary_mode_select,
                     initial_source_select};
      cfg_sync_q <= cfg_meta_q;
      boot_q     <= boot_d;
      sw_q       <= sw_d;
      cur_q      <= cur_d;
      new_q      <= new_d;
      pmode_q    <= pmode_d;
      div_q      <= div_d;
      fbd_q      <= fbd_d;
      swreq_q    <= swreq_d;
    end
  end

  // pll: prescaler, rate multiplier, postscaler and start-up timer
  always_comb begin
    pll_use = is_pll(cur_q) | ((sw_q != scps_pkg::SW_IDLE) & is_pll(new_q));
    pll_pri = ((sw_q != scps_pkg::SW_IDLE) & is_pll(new_q))
            ? (new_q == scps_pkg::SRC_PRIMARY_PLL)
            : (cur_q == scps_pkg::SRC_PRIMARY_PLL);
    pll_in   = pll_pri ? pri_tick : frc_tick;
    vco_tick = pll_use & pll_in &
               (pre_cnt_q == ({1'b0, act_pre_q} + `SCPS_PRE_OFS));
    n2   = post_factor(act_post_q);
    m    = {3'h0, act_fb_q} + `SCPS_FB_OFS;
    emit = pll_use & (acc_q >= n2);
    pre_cnt_d  = pre_cnt_q;
    act_pre_d  = act_pre_q;
    act_post_d = act_post_q;
    act_fb_d   = act_fb_q;
    if (~pll_use | vco_tick) begin
      act_pre_d  = div_q.pre;
      act_post_d = div_q.post;
      act_fb_d   = fbd_q;
      pre_cnt_d  = 6'd0;
    end else if (pll_in) begin
      pre_cnt_d = pre_cnt_q + 6'd1;
    end
    acc_d = acc_q - (emit ? n2 : 12'd0) + (vco_tick ? m : 12'd0);
    if (~pll_use) begin
      acc_d = 12'd0;
    end
    pll_tick_d = emit;
    lock_cnt_d = lock_cnt_q;
    if (~pll_use | wr_div | wr_fbd | (pll_pri != pll_pri_q)) begin
      lock_cnt_d = 12'd0;
    end else if (lock_cnt_q != `SCPS_LOCK_CYC) begin
      lock_cnt_d = lock_cnt_q + 12'd1;
    end
    lock_d = (lock_cnt_q == `SCPS_LOCK_CYC);
  end

  // pll registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_pri_q  <= 1'b0;
      pre_cnt_q  <= 6'd0;
      act_pre_q  <= 5'd0;
      act_post_q <= 2'd0;
      act_fb_q   <= 9'd0;
      acc_q      <= 12'd0;
      pll_tick_q <= 1'b0;
      lock_cnt_q <= 12'd0;
      lock_q     <= 1'b0;
    end else begin
      pll_pri_q  <= pll_pri;
      pre_cnt_q  <= pre_cnt_d;
      act_pre_q  <= act_pre_d;
      act_post_q <= act_post_d;
      act_fb_q   <= act_fb_d;
      acc_q      <= acc_d;
      pll_tick_q <= pll_tick_d;
      lock_cnt_q <= lock_cnt_d;
      lock_q     <= lock_d;
    end
  end

  // fast rc by 16 and by 2..256, new factor taken at wrap only
  always_comb begin
    rcn_last  = 8'((`SCPS_RCDIV_BASE << act_rc_q) - 9'd1);
    rc16_tick = frc_tick & (rc16_q == `SCPS_RC16_LAST);
    rcn_tick  = frc_tick & (rcn_q == rcn_last);
    rc16_d    = frc_tick ? rc16_q + 4'd1 : rc16_q;
    rcn_d     = rcn_q;
    act_rc_d  = act_rc_q;
    if (rcn_tick) begin
      rcn_d    = 8'd0;
      act_rc_d = div_q.rc_div;
    end else if (frc_tick) begin
      rcn_d = rcn_q + 8'd1;
    end
  end

  // system clock taps and their products
  always_comb begin
    osc_d   = boot_done & pick_tick(cur_q, tap);
    phase_d = osc_d ? ~phase_q : phase_q;
    cyc_d   = osc_d & phase_q;
    xdrv_d  = ((pmode_q == scps_pkg::PM_CRYSTAL) |
               (pmode_q == scps_pkg::PM_FAST_XTL)) &
              ((cur_q == scps_pkg::SRC_PRIMARY) |
               (cur_q == scps_pkg::SRC_PRIMARY_PLL) |
               (new_q == scps_pkg::SRC_PRIMARY) |
               (new_q == scps_pkg::SRC_PRIMARY_PLL));
    mode_d  = mode_of(cur_q, pmode_q);
  end

  // divider and output registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc16_q   <= 4'h0;
      rcn_q    <= 8'h00;
      act_rc_q <= 3'h0;
      osc_q    <= 1'b0;
      phase_q  <= 1'b0;
      cyc_q    <= 1'b0;
      wdt_q    <= 1'b0;
      xdrv_q   <= 1'b0;
      mode_q   <= scps_pkg::MODE_FAST_RC;
    end else begin
      rc16_q   <= rc16_d;
      rcn_q    <= rcn_d;
      act_rc_q <= act_rc_d;
      osc_q    <= osc_d;
      phase_q  <= phase_d;
      cyc_q    <= cyc_d;
      wdt_q    <= internal_low_power_rc_tick;
      xdrv_q   <= xdrv_d;
      mode_q   <= mode_d;
    end
  end

  // ports straight from registers
  assign hrdata            = rdata_q;
  assign hreadyout         = rdy_q;
  assign hresp             = resp_q;
  assign osc_tick          = osc_q;
  assign cycle_tick        = cyc_q;
  assign watchdog_ref_tick = wdt_q;
  assign crystal_drive_en  = xdrv_q;
  assign current_source    = cur_q;
  assign clock_mode        = mode_q;
  assign pll_locked        = lock_q;

endmodule // scps_clock_select
`default_nettype wire

// ==== tb/scps_osc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module scps_osc_model #(
  parameter int HF = 2,
  parameter int HL = 10,
  parameter int HS = 12,
  parameter int HP = 3
) (
  // oscillator levels
  output var logic fast_rc_osc,
  output var logic low_power_rc_osc,
  output var logic secondary_osc,
  output var logic primary_osc1
);
  // free running sources, half periods in 8 ns steps, off the bench edge
  initial begin
    {fast_rc_osc, low_power_rc_osc, secondary_osc, primary_osc1} = 4'h0;
    #3;
    fork
      forever #(HF * 8) fast_rc_osc = ~fast_rc_osc;
      forever #(HL * 8) low_power_rc_osc = ~low_power_rc_osc;
      forever #(HS * 8) secondary_osc = ~secondary_osc;
      forever #(HP * 8) primary_osc1 = ~primary_osc1;
    join
  end
endmodule // scps_osc_model
`default_nettype wire

// ==== tb/scps_clock_select_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module scps_clock_select_properties (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  // pins and products
  input wire logic        low_power_rc_osc,
  input wire logic [2:0]  initial_source_select,
  input wire logic        config_blank,
  input wire logic        osc_tick,
  input wire logic        cycle_tick,
  input wire logic        watchdog_ref_tick,
  input wire logic        crystal_drive_en,
  input wire logic [2:0]  current_source,
  input wire logic [3:0]  clock_mode,
  input wire logic        pll_locked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0]  half_q, half_d;
  logic [3:0]  boot_q, boot_d;
  logic [11:0] lock_q, lock_d;
  logic [3:0]  mode_src;
  logic        div_wr;
  // osc ticks since last cycle tick, cycles since reset and divider write
  always_comb begin
    div_wr = hsel && htrans[1] && hready && hwrite &&
             (haddr[7:0] == 8'h04 || haddr[7:0] == 8'h08);
    half_d = cycle_tick ? 2'h0 : half_q + {1'b0, osc_tick};
    boot_d = (boot_q == 4'hf) ? boot_q : boot_q + 4'h1;
    lock_d = div_wr ? 12'h000 : (lock_q == 12'hfff) ? lock_q : lock_q + 12'h1;
    mode_src = (clock_mode < 4'h2) ? clock_mode : (clock_mode < 4'h5) ?
               4'h2 : (clock_mode < 4'h8) ? 4'h3 : clock_mode - 4'h4;
  end
  // helper registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 2'h0;
      boot_q <= 4'h0;
      lock_q <= 12'h000;
    end else begin
      half_q <= half_d;
      boot_q <= boot_d;
      lock_q <= lock_d;
    end
  end
  AST_BLANK_FAST_RC: assert property (
    (boot_q == 4'h8 && config_blank) |-> current_source == 3'h0)
    else $error("blank configuration did not select fast rc");
  AST_BOOT_SOURCE: assert property (
    (boot_q == 4'h8 && !config_blank) |->
    current_source == initial_source_select)
    else $error("power-on source differs from configuration");
  AST_MODE_RANGE: assert property (clock_mode <= 4'hb)
    else $error("clock mode outside the twelve modes");
  AST_MODE_SOURCE: assert property (
    ($stable(current_source) && $stable(clock_mode)) |->
    mode_src[2:0] == current_source)
    else $error("clock mode and current source disagree");
  AST_HALF_LIMIT: assert property (half_q <= 2'h1)
    else $error("cycle tick missing after two oscillator ticks");
  AST_HALF_CAUSE: assert property (
    cycle_tick |-> (half_q == 2'h1 && osc_tick))
    else $error("cycle tick not on every second oscillator tick");
  AST_WDOG_REF: assert property (
    $rose(low_power_rc_osc) |-> ##[2:5] watchdog_ref_tick)
    else $error("low-power rc rise gave no watchdog tick");
  AST_LOCK_TIME: assert property (
    $rose(pll_locked) |-> lock_q >= 12'd2040)
    else $error("lock reported before start-up time");
  AST_EXT_NO_DRIVE: assert property (
    (clock_mode == 4'h2 || clock_mode == 4'h5) |-> !crystal_drive_en)
    else $error("crystal driven in external clock mode");
endmodule // scps_clock_select_properties
bind scps_clock_select scps_clock_select_properties
  i_scps_clock_select_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .low_power_rc_osc(low_power_rc_osc),
  .initial_source_select(initial_source_select),
  .config_blank(config_blank), .osc_tick(osc_tick), .cycle_tick(cycle_tick),
  .watchdog_ref_tick(watchdog_ref_tick), .crystal_drive_en(crystal_drive_en),
  .current_source(current_source), .clock_mode(clock_mode),
  .pll_locked(pll_locked));
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        ref_clk, rst_n, hsel, hwrite, hready, hresp, blank;
  logic        f_rc, lp_rc, sec, pri, o_tick, c_tick, xtal, locked;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, pm;
  logic [2:0]  hsize, cur, isel;
  logic [3:0]  mode;
  int          mismatches, tests_run, c, t;
  // switch order passes through plain fast rc between pll modes
  logic [2:0]  src_tab [9] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h1,
                               3'h0, 3'h0};
  int          per_tab [9] = '{6, 9, 24, 20, 64, 4, 6, 4, 4};

  scps_osc_model i_scps_osc_model (.fast_rc_osc(f_rc),
    .low_power_rc_osc(lp_rc), .secondary_osc(sec), .primary_osc1(pri));
  scps_clock_select i_scps_clock_select (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .fast_rc_osc(f_rc),
    .low_power_rc_osc(lp_rc), .secondary_osc(sec), .primary_osc1(pri),
    .initial_source_select(isel), .primary_mode_select(pm),
    .config_blank(blank), .osc_tick(o_tick), .cycle_tick(c_tick),
    .watchdog_ref_tick(), .crystal_drive_en(xtal), .current_source(cur),
    .clock_mode(mode), .pll_locked(locked));

  // bench clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus phase, bounded wait for hready
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      chk(32'h0, 32'h1);
      give_verdict;
    end
  endtask

  // single word transfer, read data left in rd
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  // reset with a given configuration word
  task boot(input logic b, input logic [2:0] s);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    blank <= b;
    isel <= s;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask

  // cycles and cycle ticks over n osc ticks, after two settling ticks
  task meas(input int n);
    int k, g;
    c = 0;
    t = 0;
    k = 0;
    g = 0;
    while (k < n + 2 && g < 20000) begin
      @(negedge ref_clk);
      g++;
      c += (k >= 2);
      t += (k >= 2 && c_tick === 1'b1);
      k += (o_tick === 1'b1);
    end
    if (g >= 20000) begin
      chk(32'h0, 32'h1);
      give_verdict;
    end
  endtask

  // request a switch and poll until the request bit clears
  task sw(input logic [2:0] s);
    int n;
    xfer(1'b1, 8'h00, {20'h0, 1'b0, s, 8'h01});
    n = 0;
    do begin
      xfer(1'b0, 8'h00, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 1500);
    if (rd[0] !== 1'b0) begin
      chk(32'h0, 32'h1);
      give_verdict;
    end
  endtask

  // main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    pm = 2'h0;
    rst_n = 1'b0;
    blank = 1'b1;
    isel = 3'h2;
    boot(1'b1, 3'h2);
    chk(cur, 3'h0);
    pm <= 2'h1;
    boot(1'b0, 3'h2);
    chk(xtal, 1'b1);
    chk(mode, 4'h3);
    pm <= 2'h0;
    boot(1'b0, 3'h7);
    chk(cur, 3'h7);
    chk(mode, 4'hb);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h40);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h30);
    xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0b);
    for (int f = 0; f < 8; f++) begin
      xfer(1'b1, 8'h04, (f << 8) | 32'h84);
      meas(4);
      chk(c, 16 << (f + 1));
      chk(t, 2);
    end
    xfer(1'b1, 8'h08, 32'h1e);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1e);
    for (int i = 0; i < 9; i++) begin
      sw(src_tab[i]);
      chk(cur, src_tab[i]);
      chk(rd & ~32'h20, {17'h0, src_tab[i], 1'b0, src_tab[i], 8'h00});
      chk(xtal, 1'b0);
      if (src_tab[i] == 3'h1 || src_tab[i] == 3'h3) begin
        chk(rd[5], 1'b1);
        chk(locked, 1'b1);
      end
      meas(8);
      chk((c + 4) >> 3, per_tab[i]);
    end
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
